// File: reset_cause_pkg.sv
`default_nettype none

package reset_cause_pkg;

	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [5:0] IDX_POWER_CONTROL = 6'h00;
	localparam logic [5:0] IDX_REFERENCE_CONTROL = 6'h04;
	localparam logic [5:0] IDX_RESET_SOURCE_FLAGS = 6'h0A;
	localparam logic [5:0] IDX_POWER_INTERRUPT_ENABLE = 6'h0E;
	localparam logic [5:0] IDX_IRQ_STATUS = 6'h20;
	localparam logic [5:0] IDX_IRQ_MASK = 6'h21;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int POS_SW_POR_TRIGGER = 3;
	localparam int POS_SW_BOR_TRIGGER = 2;
	localparam int POS_EXT_REF_OUTPUT_ENABLE = 1;
	localparam int POS_INTERNAL_REF_ENABLE = 0;
	localparam int POS_DEEP_SLEEP_WAKE_FLAG = 15;
	localparam int POS_SUPPLY_SUPERVISOR_RESET_FLAG = 13;
	localparam int POS_SW_POWER_ON_RESET_FLAG = 10;
	localparam int POS_RESET_PIN_FLAG = 9;
	localparam int POS_SW_BROWNOUT_RESET_FLAG = 8;

	// ----------------------------------------------------------------
	// implemented bits and reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] FLAG_BITS = 16'hA700;
	localparam logic [15:0] REF_BITS = 16'h0003;
	localparam logic [15:0] TRIGGER_BITS = 16'h000C;
	localparam logic [15:0] FLAGS_RESET = 16'h0000;
	localparam logic [15:0] REF_RESET = 16'h0000;
	localparam logic [15:0] IRQ_RESET = 16'h0000;
	localparam logic [15:0] INT_ENABLE_READ = 16'h0000;

	// ----------------------------------------------------------------
	// bus answers
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	// reset causes as reported by the system reset controller
	typedef struct packed {
		logic deep_sleep_exit;
		logic supervisor_trip;
		logic brownout_trip;
		logic reset_pin;
	} reset_cause_t;

	typedef struct packed {
		logic ext_ref_output_enable;
		logic internal_ref_enable;
	} ref_enable_t;

endpackage

`default_nettype wire

// File: reset_cause_flags.sv
`timescale 1ns/1ps
`default_nettype none

module reset_cause_flags
	import reset_cause_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic por_n,
	input wire reset_cause_t cause,
	input wire logic vector_word_read,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output ref_enable_t ref_enable,
	output logic sw_por_request,
	output logic sw_bor_request,
	output logic irq
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
			input logic [3:0] strb);
		logic [15:0] res;
		res = old;
		if (strb[0]) begin
			res[7:0] = data[7:0];
		end
		if (strb[1]) begin
			res[15:8] = data[15:8];
		end
		return res;
	endfunction

	function automatic logic is_mapped(input logic [5:0] idx);
		return idx == IDX_POWER_CONTROL || idx == IDX_REFERENCE_CONTROL ||
			idx == IDX_RESET_SOURCE_FLAGS || idx == IDX_POWER_INTERRUPT_ENABLE ||
			idx == IDX_IRQ_STATUS || idx == IDX_IRQ_MASK;
	endfunction

	// highest set flag, bit 15 first; the vector word clears one cause per read
	function automatic logic [15:0] top_flag(input logic [15:0] f);
		logic [15:0] res;
		logic found;
		res = 16'h0000;
		found = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			if (f[i] && !found) begin
				res[i] = 1'b1;
				found = 1'b1;
			end
		end
		return res;
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic aw_hold_r;
	logic [5:0] aw_idx_r;
	logic w_hold_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic awready_r;
	logic wready_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic arready_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	logic [15:0] flags_r;
	logic [15:0] ref_r;
	logic [15:0] trigger_r;
	logic [15:0] status_r;
	logic [15:0] mask_r;
	logic irq_r;

	// ----------------------------------------------------------------
	// write channel decode
	// ----------------------------------------------------------------
	wire aw_fire = awvalid && awready_r;
	wire w_fire = wvalid && wready_r;
	wire aw_hold_nxt_pre = aw_hold_r || aw_fire;
	wire w_hold_nxt_pre = w_hold_r || w_fire;
	wire wr_go = aw_hold_r && w_hold_r && !bvalid_r;
	wire b_fire = bvalid_r && bready;
	wire aw_hold_nxt = aw_hold_nxt_pre && !wr_go;
	wire w_hold_nxt = w_hold_nxt_pre && !wr_go;
	wire bvalid_nxt = wr_go || (bvalid_r && !b_fire);
	wire awready_nxt = !aw_hold_nxt && !bvalid_nxt && !aw_fire;
	wire wready_nxt = !w_hold_nxt && !bvalid_nxt && !w_fire;
	wire [1:0] bresp_nxt = is_mapped(aw_idx_r) ? RESP_OKAY : RESP_SLVERR;

	wire wr_ctl = wr_go && aw_idx_r == IDX_POWER_CONTROL;
	wire wr_ref = wr_go && aw_idx_r == IDX_REFERENCE_CONTROL;
	wire wr_flags = wr_go && aw_idx_r == IDX_RESET_SOURCE_FLAGS;
	wire wr_status = wr_go && aw_idx_r == IDX_IRQ_STATUS;
	wire wr_mask = wr_go && aw_idx_r == IDX_IRQ_MASK;

	// ----------------------------------------------------------------
	// software reset triggers
	// ----------------------------------------------------------------
	wire [15:0] ctl_wr_word = merge16(16'h0000, w_data_r, w_strb_r);
	wire sw_por_fire = wr_ctl && ctl_wr_word[POS_SW_POR_TRIGGER];
	wire sw_bor_fire = wr_ctl && ctl_wr_word[POS_SW_BOR_TRIGGER];
	// trigger bits live one cycle only, so only a read accepted in that cycle finds them set
	wire [15:0] trigger_nxt = wr_ctl ? (ctl_wr_word & TRIGGER_BITS) : 16'h0000;

	// ----------------------------------------------------------------
	// reset source flags
	// ----------------------------------------------------------------
	wire power_fail = cause.supervisor_trip || cause.brownout_trip;
	wire [15:0] flag_set = {
		cause.deep_sleep_exit,
		1'b0,
		cause.supervisor_trip,
		2'b00,
		sw_por_fire,
		cause.reset_pin,
		sw_bor_fire,
		8'h00
	};
	wire [15:0] vec_clear = vector_word_read ? top_flag(flags_r) : 16'h0000;
	wire [15:0] flags_base = wr_flags ? merge16(flags_r, w_data_r, w_strb_r) : flags_r;
	// set wins over a clear arriving in the same cycle
	wire [15:0] flags_set_applied = ((flags_base & ~vec_clear) | flag_set) & FLAG_BITS;
	// a power failure wipes the wake record even if a wake is reported with it
	wire [15:0] flags_nxt = power_fail ?
		(flags_set_applied & ~(16'h0001 << POS_DEEP_SLEEP_WAKE_FLAG)) : flags_set_applied;

	// ----------------------------------------------------------------
	// reference control and interrupt registers
	// ----------------------------------------------------------------
	wire [15:0] ref_nxt = wr_ref ? (merge16(ref_r, w_data_r, w_strb_r) & REF_BITS) : ref_r;
	wire [15:0] w1c_word = wr_status ? merge16(16'h0000, w_data_r, w_strb_r) : 16'h0000;
	wire [15:0] status_nxt = ((status_r & ~w1c_word) | flag_set) & FLAG_BITS;
	wire [15:0] mask_nxt = wr_mask ? (merge16(mask_r, w_data_r, w_strb_r) & FLAG_BITS) : mask_r;
	wire irq_nxt = |(status_r & mask_r);

	// ----------------------------------------------------------------
	// read channel decode
	// ----------------------------------------------------------------
	wire ar_fire = arvalid && arready_r;
	wire [5:0] ar_idx = araddr[7:2];
	wire rvalid_nxt = ar_fire || (rvalid_r && !rready);
	wire arready_nxt = !rvalid_nxt;
	wire [15:0] rd_word =
		ar_idx == IDX_POWER_CONTROL ? trigger_r :
		ar_idx == IDX_REFERENCE_CONTROL ? ref_r :
		ar_idx == IDX_RESET_SOURCE_FLAGS ? flags_r :
		ar_idx == IDX_POWER_INTERRUPT_ENABLE ? INT_ENABLE_READ :
		ar_idx == IDX_IRQ_STATUS ? status_r :
		ar_idx == IDX_IRQ_MASK ? mask_r : 16'h0000;
	wire [1:0] rresp_nxt = is_mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;

	// ----------------------------------------------------------------
	// bus registers
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end else begin
			aw_hold_r <= aw_hold_nxt;
			w_hold_r <= w_hold_nxt;
			awready_r <= awready_nxt;
			wready_r <= wready_nxt;
			bvalid_r <= bvalid_nxt;
			if (wr_go) begin
				bresp_r <= bresp_nxt;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (aw_fire) begin
			aw_idx_r <= awaddr[7:2];
		end
		if (w_fire) begin
			w_data_r <= wdata;
			w_strb_r <= wstrb;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= RESP_OKAY;
		end else begin
			arready_r <= arready_nxt;
			rvalid_r <= rvalid_nxt;
			if (ar_fire) begin
				rdata_r <= {16'h0000, rd_word};
				rresp_r <= rresp_nxt;
			end
		end
	end

	// ----------------------------------------------------------------
	// block registers
	// ----------------------------------------------------------------
	// flags sit on the power-on reset only, so the system reset leaves them
	always_ff @(posedge aclk) begin
		if (!por_n) begin
			flags_r <= FLAGS_RESET;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ref_r <= REF_RESET;
			trigger_r <= 16'h0000;
			status_r <= IRQ_RESET;
			mask_r <= IRQ_RESET;
			irq_r <= 1'b0;
		end else begin
			ref_r <= ref_nxt;
			trigger_r <= trigger_nxt;
			status_r <= status_nxt;
			mask_r <= mask_nxt;
			irq_r <= irq_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign awready = awready_r;
	assign wready = wready_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign arready = arready_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;
	// one assignment for the whole carrier, so no field has a second driver
	assign ref_enable = {ref_r[POS_EXT_REF_OUTPUT_ENABLE], ref_r[POS_INTERNAL_REF_ENABLE]};
	assign sw_por_request = trigger_r[POS_SW_POR_TRIGGER];
	assign sw_bor_request = trigger_r[POS_SW_BOR_TRIGGER];
	assign irq = irq_r;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	AST_EXT_REF: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_ref && w_strb_r[0] |=> ref_enable.ext_ref_output_enable == $past(w_data_r[1]))
		else $error("external reference enable does not follow write");

	AST_INT_REF: assert property (@(posedge aclk) disable iff (!aresetn)
		!wr_ref |=> ref_enable.internal_ref_enable == $past(ref_enable.internal_ref_enable))
		else $error("internal reference enable changed without a write");

	AST_IE_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
		ar_fire && ar_idx == IDX_POWER_INTERRUPT_ENABLE |=> rvalid && rdata == 32'h00000000)
		else $error("interrupt enable register read nonzero");

	AST_WAKE_SET: assert property (@(posedge aclk) disable iff (!por_n)
		$rose(flags_r[POS_DEEP_SLEEP_WAKE_FLAG]) && !$past(wr_flags) |-> $past(cause.deep_sleep_exit))
		else $error("wake flag set without deep sleep exit");

	AST_WAKE_CLR: assert property (@(posedge aclk) disable iff (!por_n)
		power_fail |=> !flags_r[POS_DEEP_SLEEP_WAKE_FLAG])
		else $error("power failure did not clear wake flag");

	AST_SUPERVISOR: assert property (@(posedge aclk) disable iff (!por_n)
		cause.supervisor_trip |=> flags_r[POS_SUPPLY_SUPERVISOR_RESET_FLAG])
		else $error("supervisor flag not set");

	AST_SW_POR: assert property (@(posedge aclk) disable iff (!aresetn || !por_n)
		sw_por_fire |=> flags_r[POS_SW_POWER_ON_RESET_FLAG] && sw_por_request ##1 !sw_por_request)
		else $error("software power-on reset flag or pulse wrong");

	AST_PIN: assert property (@(posedge aclk) disable iff (!por_n)
		$rose(flags_r[POS_RESET_PIN_FLAG]) && !$past(wr_flags) |-> $past(cause.reset_pin))
		else $error("pin flag set without pin reset");

	AST_SW_BOR: assert property (@(posedge aclk) disable iff (!aresetn || !por_n)
		sw_bor_fire |=> flags_r[POS_SW_BROWNOUT_RESET_FLAG] && sw_bor_request ##1 !sw_bor_request)
		else $error("software brownout flag or pulse wrong");

	AST_VEC_CLR: assert property (@(posedge aclk) disable iff (!por_n)
		vector_word_read && flags_r[POS_RESET_PIN_FLAG] && !cause.reset_pin &&
		(flags_r & 16'hFC00) == 16'h0000 && !wr_flags |=> !flags_r[POS_RESET_PIN_FLAG])
		else $error("vector word read did not clear pin flag");

	AST_RSVD: assert property (@(posedge aclk) disable iff (!por_n)
		(flags_r & ~FLAG_BITS) == 16'h0000)
		else $error("reserved flag bit set");

	AST_KEEP: assert property (@(posedge aclk) disable iff (!por_n)
		!aresetn && flag_set == 16'h0000 && !vector_word_read && !power_fail |=> flags_r == $past(flags_r))
		else $error("flags lost during system reset");

endmodule

`default_nettype wire

// File: reset_cause_flags_test.sv
`timescale 1ns/1ps
`default_nettype none

module reset_cause_flags_test import reset_cause_pkg::*;;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	localparam logic [7:0] A_PWR = {IDX_POWER_CONTROL, 2'b00};
	localparam logic [7:0] A_REF = {IDX_REFERENCE_CONTROL, 2'b00};
	localparam logic [7:0] A_FLG = {IDX_RESET_SOURCE_FLAGS, 2'b00};
	localparam logic [7:0] A_IE = {IDX_POWER_INTERRUPT_ENABLE, 2'b00};
	localparam logic [7:0] A_STS = {IDX_IRQ_STATUS, 2'b00};
	localparam logic [7:0] A_MSK = {IDX_IRQ_MASK, 2'b00};
	logic aclk, aresetn, por_n, vector_word_read;
	reset_cause_t cause;
	logic [7:0] awaddr, araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	ref_enable_t ref_enable;
	logic sw_por_request, sw_bor_request, irq;
	int error_cnt, check_count, cyc, por_cnt, bor_cnt;

	reset_cause_flags #(.ADDR_W(8)) dut (.aclk(aclk), .aresetn(aresetn), .por_n(por_n), .cause(cause),
		.vector_word_read(vector_word_read), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.ref_enable(ref_enable), .sw_por_request(sw_por_request), .sw_bor_request(sw_bor_request), .irq(irq));

	// ------------------------------------------------------------
	// clock, watchdog and pulse counters
	// ------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	// the whole run needs a few hundred cycles, so this ceiling only catches a hung handshake
	always @(posedge aclk) begin
		cyc++;
		if (sw_por_request === 1'b1) por_cnt++;
		if (sw_bor_request === 1'b1) bor_cnt++;
		if (cyc == 20000) begin
			error_cnt++;
			tally_and_finish();
		end
	end

	// ------------------------------------------------------------
	// bus and check tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {16'h0000, d};
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				done = 1'b1;
				bready <= 1'b0;
				chk({30'h0, bresp}, {30'h0, er});
			end
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				done = 1'b1;
				rready <= 1'b0;
				chk(rdata, exp);
				chk({30'h0, rresp}, {30'h0, er});
			end
		end
	endtask

	task automatic pulse_cause(input reset_cause_t c, input logic hold_reset);
		@(posedge aclk);
		cause <= c;
		aresetn <= ~hold_reset;
		@(posedge aclk);
		cause <= '0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
	endtask

	task automatic pulse_vector();
		@(posedge aclk);
		vector_word_read <= 1'b1;
		@(posedge aclk);
		vector_word_read <= 1'b0;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset_and_reserved();
		rd(A_FLG, 32'h0, RESP_OKAY);
		rd(A_REF, 32'h0, RESP_OKAY);
		wr(A_IE, 16'hFFFF, RESP_OKAY);
		rd(A_IE, 32'h0, RESP_OKAY);
		wr(8'hFC, 16'hFFFF, RESP_SLVERR);
		rd(8'hFC, 32'h0, RESP_SLVERR);
		wr(A_FLG, 16'hFFFF, RESP_OKAY);
		rd(A_FLG, 32'h0000A700, RESP_OKAY);
		$display("test reset_and_reserved done");
	endtask

	task automatic t_reference();
		logic [1:0] v;
		for (int i = 0; i < 4; i++) begin
			v = 2'(3 - i);
			wr(A_REF, {14'h0, v}, RESP_OKAY);
			repeat (2) @(posedge aclk);
			chk({30'h0, ref_enable}, {30'h0, v});
			rd(A_REF, {30'h0, v}, RESP_OKAY);
		end
		$display("test reference done");
	endtask

	task automatic t_hw_causes();
		wr(A_FLG, 16'h0000, RESP_OKAY);
		// flags are recorded while the system reset is held and survive its release
		pulse_cause(4'b1000, 1'b1);
		rd(A_FLG, 32'h00008000, RESP_OKAY);
		pulse_cause(4'b0001, 1'b1);
		rd(A_FLG, 32'h00008200, RESP_OKAY);
		pulse_cause(4'b0100, 1'b1);
		rd(A_FLG, 32'h00002200, RESP_OKAY);
		wr(A_FLG, 16'h8000, RESP_OKAY);
		rd(A_FLG, 32'h00008000, RESP_OKAY);
		pulse_cause(4'b0010, 1'b0);
		rd(A_FLG, 32'h0, RESP_OKAY);
		// wake and supervisor trip reported together: the power failure must win
		pulse_cause(4'b1100, 1'b1);
		rd(A_FLG, 32'h00002000, RESP_OKAY);
		wr(A_FLG, 16'h0000, RESP_OKAY);
		rd(A_FLG, 32'h0, RESP_OKAY);
		$display("test hw_causes done");
	endtask

	task automatic t_sw_triggers();
		int p0, b0;
		p0 = por_cnt;
		b0 = bor_cnt;
		wr(A_PWR, 16'h0008, RESP_OKAY);
		rd(A_PWR, 32'h0, RESP_OKAY);
		rd(A_FLG, 32'h00000400, RESP_OKAY);
		chk(32'(por_cnt - p0), 32'h1);
		wr(A_PWR, 16'h0004, RESP_OKAY);
		rd(A_PWR, 32'h0, RESP_OKAY);
		rd(A_FLG, 32'h00000500, RESP_OKAY);
		chk(32'(bor_cnt - b0), 32'h1);
		chk(32'(por_cnt - p0), 32'h1);
		$display("test sw_triggers done");
	endtask

	task automatic t_vector_clear();
		logic [31:0] exp_tab [5];
		exp_tab = '{32'h2700, 32'h0700, 32'h0300, 32'h0100, 32'h0000};
		wr(A_FLG, 16'hA700, RESP_OKAY);
		// each read of the vector word retires only the highest pending flag
		for (int i = 0; i < 5; i++) begin
			pulse_vector();
			rd(A_FLG, exp_tab[i], RESP_OKAY);
		end
		$display("test vector_clear done");
	endtask

	task automatic t_irq_and_por();
		wr(A_MSK, 16'h0000, RESP_OKAY);
		wr(A_STS, 16'hFFFF, RESP_OKAY);
		pulse_cause(4'b0001, 1'b0);
		rd(A_STS, 32'h00000200, RESP_OKAY);
		chk({31'h0, irq}, 32'h0);
		wr(A_MSK, 16'h0200, RESP_OKAY);
		repeat (3) @(posedge aclk);
		chk({31'h0, irq}, 32'h1);
		wr(A_STS, 16'h0200, RESP_OKAY);
		repeat (3) @(posedge aclk);
		chk({31'h0, irq}, 32'h0);
		rd(A_FLG, 32'h00000200, RESP_OKAY);
		@(posedge aclk);
		por_n <= 1'b0;
		repeat (2) @(posedge aclk);
		por_n <= 1'b1;
		rd(A_FLG, 32'h0, RESP_OKAY);
		$display("test irq_and_por done");
	endtask

	// ------------------------------------------------------------
	// closing and main sequence
	// ------------------------------------------------------------
	task automatic tally_and_finish();
		$display("checks=%0d mismatches=%0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		aresetn = 1'b0;
		por_n = 1'b0;
		cause = '0;
		vector_word_read = 1'b0;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		wstrb = '0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		por_n <= 1'b1;
		t_reset_and_reserved();
		t_reference();
		t_hw_causes();
		t_sw_triggers();
		t_vector_clear();
		t_irq_and_por();
		tally_and_finish();
	end
endmodule

`default_nettype wire
